// ---- beat_detector.sv ----
/*
 Heart-beat interval detector: config registers, threshold detection,
 hold-off, interval counter, beat flag with clearing policies, interrupt.
 Assumes filtered channel samples arrive as one-cycle valid strobes on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module beat_detector (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire beat_pkg::bus_req_s req,
    output logic            [23:0] rdata,
    input  wire beat_pkg::sample_s  sample,
    output logic                   irq,
    output logic                   secondary_irq_pin
);
    import beat_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [23:0] beat_detect_config_a;
    logic [23:0] beat_detect_config_b;
    logic [23:0] interrupt_manage_word;
    logic [23:0] general_config_word;
    logic [1:0]  irq_mask;
    logic [13:0] beat_interval;
    logic        beat_event_flag;
    logic        wrap_flag;

    logic wr_a, wr_b, wr_m, wr_g, wr_k;
    logic rd_status, rd_interval;
    assign wr_a        = req.wr && req.addr == ADDR_CONFIG_A;
    assign wr_b        = req.wr && req.addr == ADDR_CONFIG_B;
    assign wr_m        = req.wr && req.addr == ADDR_MANAGE;
    assign wr_g        = req.wr && req.addr == ADDR_GENERAL;
    assign wr_k        = req.wr && req.addr == ADDR_IRQ_MASK;
    assign rd_status   = req.rd && req.addr == ADDR_STATUS;
    assign rd_interval = req.rd && req.addr == ADDR_INTERVAL;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            beat_detect_config_a  <= CONFIG_A_RESET;
            beat_detect_config_b  <= CONFIG_B_RESET;
            interrupt_manage_word <= MANAGE_RESET;
            general_config_word   <= GENERAL_RESET;
            irq_mask              <= 2'h0;
        end else begin
            // Unused bits are not stored so they read as zero
            if (wr_a) begin
                beat_detect_config_a <= req.wdata & 24'hFFBF00;
            end
            if (wr_b) begin
                beat_detect_config_b <= req.wdata & 24'h3F3700;
            end
            if (wr_m) begin
                interrupt_manage_word <= req.wdata & 24'h000031;
            end
            if (wr_g) begin
                general_config_word <= req.wdata & 24'h300000;
            end
            if (wr_k) begin
                irq_mask <= req.wdata[1:0];
            end
        end
    end

    // Config fields
    logic [3:0] qrs_window_width;
    logic [3:0] gain_sel;
    logic       beat_detect_enable;
    logic       channel_enable;
    logic [1:0] peak_avg_weight;
    logic [3:0] peak_threshold_scale;
    logic [5:0] min_holdoff;
    logic [1:0] interval_avg_weight;
    logic [2:0] holdoff_scale;
    logic [1:0] beat_flag_clear_policy;
    logic [1:0] master_clock_select;
    assign qrs_window_width       = beat_detect_config_a[WINDOW_LSB +: 4];
    assign gain_sel               = beat_detect_config_a[GAIN_LSB +: 4];
    assign beat_detect_enable     = beat_detect_config_a[EN_BIT];
    assign peak_avg_weight        = beat_detect_config_a[PEAK_WT_LSB +: 2];
    assign peak_threshold_scale   = beat_detect_config_a[THRESH_LSB +: 4];
    assign min_holdoff            = beat_detect_config_b[HOLD_MIN_LSB +: 6];
    assign interval_avg_weight    = beat_detect_config_b[IVL_WT_LSB +: 2];
    assign holdoff_scale          = beat_detect_config_b[HOLD_SCALE_LSB +: 3];
    assign beat_flag_clear_policy = interrupt_manage_word[CLRP_LSB +: 2];
    assign channel_enable         = interrupt_manage_word[CHEN_BIT];
    assign master_clock_select    = general_config_word[FMS_LSB +: 2];

    logic active;
    assign active = beat_detect_enable && channel_enable;

    // ----------------------------------------------------------------
    // Interval tick
    // ----------------------------------------------------------------
    logic [19:0] tick_cnt;
    logic [19:0] tick_len;
    logic        tick;
    // tick length from master clock select
    always_comb begin
        if (master_clock_select == 2'h0) begin
            tick_len = 20'(TICK_CYC_00);
        end else if (master_clock_select == 2'h3) begin
            tick_len = 20'(TICK_CYC_11);
        end else begin
            tick_len = 20'(TICK_CYC_01);
        end
    end
    assign tick = active && tick_cnt >= tick_len - 20'h1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 20'h0;
        end else if (!active || tick) begin
            tick_cnt <= 20'h0;
        end else begin
            tick_cnt <= tick_cnt + 20'h1;
        end
    end

    // ----------------------------------------------------------------
    // Signal path: gain and window average
    // ----------------------------------------------------------------
    logic [15:0] window [0:11];
    logic [19:0] win_sum;
    logic [3:0]  win_len;
    logic [15:0] win_avg;
    logic [31:0] scaled;
    logic [15:0] level;

    assign win_len = (qrs_window_width > 4'h3) ? 4'hC : 4'(4'h6 + {qrs_window_width[1:0], 1'b0});

    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_win
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    window[gi] <= 16'h0000;
                end else if (sample.valid) begin
                    window[gi] <= (gi == 0) ? sample.level : window[(gi == 0) ? 0 : gi - 1];
                end
            end
        end
    endgenerate

    always_comb begin
        win_sum = 20'h0;
        for (int i = 0; i < 12; i++) begin
            if (4'(i) < win_len) begin
                win_sum = win_sum + {4'h0, window[i]};
            end
        end
    end
    assign win_avg = 16'(win_sum / {16'h0, win_len});

    // gain 2^field; auto-scale uses unity gain and relies on the threshold
    assign scaled = (gain_sel == GAIN_AUTO) ? {16'h0, win_avg} : ({16'h0, win_avg} << gain_sel);
    assign level  = (scaled[31:16] != 16'h0) ? 16'hFFFF : scaled[15:0];

    // ----------------------------------------------------------------
    // Threshold, hold-off, beat decision
    // ----------------------------------------------------------------
    logic [15:0] peak_avg;
    logic [15:0] interval_avg;
    logic [19:0] thresh_prod;
    logic [15:0] threshold;
    logic [18:0] dyn_prod;
    logic [15:0] holdoff_dyn;
    logic [15:0] holdoff;
    logic [13:0] ivl_cnt;
    logic        beat;

    // threshold = avg * (scale+1) / 16
    assign thresh_prod = {4'h0, peak_avg} * {15'h0, 5'({1'b0, peak_threshold_scale} + 5'h1)};
    assign threshold   = thresh_prod[19:4];
    // dynamic hold-off = avg * scale / 8
    assign dyn_prod    = {3'h0, interval_avg} * {16'h0, holdoff_scale};
    assign holdoff_dyn = dyn_prod[18:3];
    assign holdoff = ({10'h0, min_holdoff} > holdoff_dyn) ? {10'h0, min_holdoff} : holdoff_dyn;
    assign beat = active && sample.valid && level > threshold && {2'h0, ivl_cnt} >= holdoff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ivl_cnt <= 14'h0;
        end else if (beat) begin
            ivl_cnt <= 14'h0;
        end else if (tick) begin
            ivl_cnt <= ivl_cnt + 14'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            beat_interval <= 14'h0;
        end else if (beat) begin
            beat_interval <= ivl_cnt;
        end
    end

    beat_average u_peak (
        .clk     (clk),
        .rst_n   (rst_n),
        .update  (beat),
        .shift   ({1'b0, peak_avg_weight} + 3'h1),
        .sample  (level),
        .average (peak_avg)
    );

    // interval average, 11 treated as 8
    beat_average u_ivl (
        .clk     (clk),
        .rst_n   (rst_n),
        .update  (beat),
        .shift   ((interval_avg_weight == 2'h3) ? 3'h3 : {1'b0, interval_avg_weight} + 3'h1),
        .sample  ({2'h0, ivl_cnt}),
        .average (interval_avg)
    );

    // ----------------------------------------------------------------
    // Beat flag and interrupt
    // ----------------------------------------------------------------
    logic self_arm;
    logic clear_flag;
    // next sample strobe after setting ends one full data cycle
    assign clear_flag = (beat_flag_clear_policy == CLR_ON_STATUS && rd_status)      // status read
                     || (beat_flag_clear_policy == CLR_ON_IVL && rd_interval)        // interval read
                     || (beat_flag_clear_policy == CLR_SELF && self_arm && sample.valid);

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            beat_event_flag <= 1'b0;
            self_arm        <= 1'b0;
        end else if (beat) begin
            beat_event_flag <= 1'b1;
            self_arm        <= 1'b1;
        end else if (clear_flag) begin
            beat_event_flag <= 1'b0;
            self_arm        <= 1'b0;
        end
    end

    // Wrap indicator is a status bit that also drives irq when its mask bit is set; it never raises a beat
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrap_flag <= 1'b0;
        end else if (tick && ivl_cnt == 14'h3FFF && !beat) begin
            wrap_flag <= 1'b1;
        end else if (wr_k == 1'b0 && req.wr && req.addr == ADDR_STATUS && req.wdata[ST_WRAP]) begin
            wrap_flag <= 1'b0;
        end
    end

    assign irq               = (beat_event_flag && irq_mask[ST_BEAT]) || (wrap_flag && irq_mask[ST_WRAP]);
    assign secondary_irq_pin = beat_event_flag;

    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 24'h0;
        end else if (!req.rd) begin
            rdata <= 24'h0;
        end else if (req.addr == ADDR_STATUS) begin
            rdata <= {22'h0, wrap_flag, beat_event_flag};
        end else if (req.addr == ADDR_IRQ_MASK) begin
            rdata <= {22'h0, irq_mask};
        end else if (req.addr == ADDR_MANAGE) begin
            rdata <= interrupt_manage_word;
        end else if (req.addr == ADDR_GENERAL) begin
            rdata <= general_config_word;
        end else if (req.addr == ADDR_CONFIG_A) begin
            rdata <= beat_detect_config_a;
        end else if (req.addr == ADDR_CONFIG_B) begin
            rdata <= beat_detect_config_b;
        end else if (req.addr == ADDR_INTERVAL) begin
            rdata <= {beat_interval, 10'h0} & 24'hFFFF00;
        end else begin
            rdata <= 24'h0;
        end
    end
endmodule : beat_detector
`default_nettype wire

// ---- beat_pkg.sv ----
/*
 Package for the heart-beat interval detector: register offsets, field
 positions, reset values, timing counts and shared types.
 Assumes a 10 MHz system clock and a host on a plain register port.
*/
package beat_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS      = 8'h01;
    localparam logic [7:0] ADDR_MANAGE      = 8'h04;
    localparam logic [7:0] ADDR_GENERAL     = 8'h10;
    localparam logic [7:0] ADDR_CONFIG_A    = 8'h1D;
    localparam logic [7:0] ADDR_CONFIG_B    = 8'h1E;
    localparam logic [7:0] ADDR_INTERVAL    = 8'h25;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h02;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int WINDOW_LSB     = 20;
    localparam int GAIN_LSB       = 16;
    localparam int EN_BIT         = 15;
    localparam int PEAK_WT_LSB    = 12;
    localparam int THRESH_LSB     = 8;
    localparam int HOLD_MIN_LSB   = 16;
    localparam int IVL_WT_LSB     = 12;
    localparam int HOLD_SCALE_LSB = 8;
    localparam int CLRP_LSB   = 4;
    localparam int CHEN_BIT   = 0;
    localparam int FMS_LSB    = 20;
    localparam int IVL_LSB    = 10;
    localparam int ST_BEAT    = 0;
    localparam int ST_WRAP    = 1;

    // ----------------------------------------------------------------
    // Reset values, clear policy codes and auto gain code
    // ----------------------------------------------------------------
    localparam logic [23:0] CONFIG_A_RESET = 24'h3F_2300;
    localparam logic [23:0] CONFIG_B_RESET = 24'h20_2400;
    localparam logic [23:0] MANAGE_RESET   = 24'h00_0000;
    localparam logic [23:0] GENERAL_RESET  = 24'h00_0000;
    localparam logic [1:0]  CLR_ON_STATUS  = 2'h0;
    localparam logic [1:0]  CLR_ON_IVL     = 2'h1;
    localparam logic [1:0]  CLR_SELF       = 2'h2;
    localparam logic [3:0]  GAIN_AUTO      = 4'hF;

    // ----------------------------------------------------------------
    // Timing: interval tick from master clock selection
    // ----------------------------------------------------------------
    localparam int CLK_HZ       = 10_000_000;
    localparam int TICK_NS_00   = 7_812_500;
    localparam int TICK_NS_01   = 8_000_000;
    localparam int TICK_NS_11   = 8_008_008;
    localparam int TICK_CYC_00  = TICK_NS_00 / (1_000_000_000 / CLK_HZ);
    localparam int TICK_CYC_01  = TICK_NS_01 / (1_000_000_000 / CLK_HZ);
    localparam int TICK_CYC_11  = TICK_NS_11 / (1_000_000_000 / CLK_HZ);

    typedef struct packed {
        logic [7:0]  addr;
        logic [23:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] level;
    } sample_s;

endpackage : beat_pkg

// ---- beat_average.sv ----
/*
 Weighted running average: avg = (new + (w-1)*avg) / w, w = 2^shift.
 Assumes a same-clock update strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module beat_average (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        update,
    input  wire logic [2:0]  shift,
    input  wire logic [15:0] sample,
    output logic      [15:0] average
);
    logic [20:0] next_sum;

    always_comb begin
        next_sum = {5'h00, average} * 21'((21'h1 << shift) - 21'h1) + {5'h00, sample};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            average <= 16'h0000;
        end else if (update) begin
            average <= 16'(next_sum >> shift);
        end
    end
endmodule : beat_average
`default_nettype wire

// ---- beat_detector_assertions.sv ----
/*
 Port checker for beat_detector, bound to every instance.
 Assumes all register traffic arrives on req as declared in beat_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module beat_detector_chk (
    input wire logic               clk,
    input wire logic               rstn,
    input wire beat_pkg::bus_req_s req,
    input wire logic        [23:0] rdata,
    input wire beat_pkg::sample_s  sample,
    input wire logic               irq,
    input wire logic               secondary_irq_pin
);
    import beat_pkg::*;
    // --------------------------------------------
    // Shadow of the fields that gate behaviour
    // --------------------------------------------
    logic [1:0] policy;
    logic [1:0] mask;
    logic       en_a;
    logic       ch_on;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            policy <= 2'h0;
            mask   <= 2'h0;
            en_a   <= 1'b0;
            ch_on  <= 1'b0;
        end else if (req.wr) begin
            if (req.addr == ADDR_MANAGE) begin
                policy <= req.wdata[CLRP_LSB +: 2];
                ch_on  <= req.wdata[CHEN_BIT];
            end
            if (req.addr == ADDR_IRQ_MASK) begin
                mask <= req.wdata[1:0];
            end
            if (req.addr == ADDR_CONFIG_A) begin
                en_a <= req.wdata[EN_BIT];
            end
        end
    end
    // --------------------------------------------
    // Properties
    // --------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence rd_of(logic [7:0] a);
        req.rd && req.addr == a;
    endsequence
    // A new sample in the same cycle may set the flag again, so it is excluded
    sequence quiet_rd(logic [7:0] a, logic [1:0] p);
        rd_of(a) ##0 (policy == p && !sample.valid);
    endsequence
    chk_rdata_idle: assert property (!$past(req.rd) |-> rdata == 24'h0)
        else $error("read data not zero outside an answer");
    chk_ivl_low_zero: assert property (rd_of(ADDR_INTERVAL) |=> rdata[9:0] == 10'h0)
        else $error("interval word low bits not zero");
    chk_cfga_unused: assert property (rd_of(ADDR_CONFIG_A) |=> (rdata & 24'h0040FF) == 24'h0)
        else $error("config a unused bits set");
    chk_cfgb_unused: assert property (rd_of(ADDR_CONFIG_B) |=> (rdata & 24'hC0C8FF) == 24'h0)
        else $error("config b unused bits set");
    chk_beat_cause: assert property ($rose(secondary_irq_pin) |-> $past(sample.valid && en_a && ch_on))
        else $error("beat flag rose without an enabled sample");
    chk_irq_masked: assert property (mask == 2'h0 |-> !irq)
        else $error("interrupt high while fully masked");
    chk_irq_beat: assert property (mask[0] && secondary_irq_pin |-> irq)
        else $error("unmasked beat flag without interrupt");
    chk_status_clr: assert property (quiet_rd(ADDR_STATUS, 2'h0) |-> ##[1:2] !secondary_irq_pin)
        else $error("status read left beat flag set");
    chk_ivl_clr: assert property (quiet_rd(ADDR_INTERVAL, 2'h1) |-> ##[1:2] !secondary_irq_pin)
        else $error("interval read left beat flag set");
    chk_status_keep: assert property (rd_of(ADDR_STATUS) ##0 (policy == 2'h1 && secondary_irq_pin)
        |=> secondary_irq_pin)
        else $error("status read cleared flag under interval policy");
endmodule : beat_detector_chk
bind beat_detector beat_detector_chk i_beat_detector_chk (
    .clk               (clk),
    .rstn              (rstn),
    .req               (req),
    .rdata             (rdata),
    .sample            (sample),
    .irq               (irq),
    .secondary_irq_pin (secondary_irq_pin)
);
`default_nettype wire

// ---- host_model.sv ----
/*
 Host side of the register port: one-cycle write and read strobes.
 Assumes the testbench checks read data one cycle after each read.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic              clk,
    output var beat_pkg::bus_req_s req
);
    import beat_pkg::*;
    initial begin
        req = '0;
    end
    // Policy 10 kept for pin-only use
    task automatic access(input logic w, input logic [7:0] a, input logic [23:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
    endtask : access
endmodule : host_model
`default_nettype wire

// ---- testbench.sv ----
/*
 Self-checking bench for beat_detector with a host model on the port.
 Assumes hold-off is programmed to zero so beats follow sample bursts.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import beat_pkg::*;
    typedef struct packed {
        logic [23:0] m;
        logic [23:0] e;
    } note_s;
    logic        clk;
    logic        rstn;
    bus_req_s    req;
    sample_s     sample;
    logic [23:0] rdata;
    logic        irq;
    logic        pin;
    logic [31:0] lfsr;
    logic        rd_d;
    int          n_fail;
    int          n_compared;
    note_s       notes[$];
    logic [7:0]  ra [8] = '{ADDR_CONFIG_A, ADDR_CONFIG_B, ADDR_MANAGE, ADDR_GENERAL,
                            ADDR_IRQ_MASK, ADDR_STATUS, ADDR_INTERVAL, 8'h7F};
    logic [23:0] rv [8] = '{24'h3F2300, 24'h202400, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
    beat_detector i_beat_detector (
        .clk               (clk),
        .rstn              (rstn),
        .req               (req),
        .rdata             (rdata),
        .sample            (sample),
        .irq               (irq),
        .secondary_irq_pin (pin)
    );
    host_model i_host_model (
        .clk (clk),
        .req (req)
    );
    always #50 clk = ~clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd(input logic [7:0] a, input logic [23:0] m, input logic [23:0] e);
        notes.push_back(note_s'{m: m, e: e});
        i_host_model.access(1'b0, a, 24'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        i_host_model.access(1'b1, a, d);
    endtask : wr
    // Big levels stay within 0x2000..0x3FFF so a burst always beats the threshold
    task automatic feed(input int n, input logic big);
        repeat (n) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            sample <= '{valid: 1'b1, level: big ? {3'h1, lfsr[12:0]} : 16'h0000};
            @(posedge clk);
            sample.valid <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : feed
    task automatic see_pin(input logic e, input logic ei);
        repeat (2) @(posedge clk);
        check("beat pin", {23'h0, pin}, {23'h0, e});
        check("irq", {23'h0, irq}, {23'h0, ei});
    endtask : see_pin
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    // --------------------------------------------
    // Read data monitor and time limit
    // --------------------------------------------
    always @(posedge clk) begin
        if (rd_d && notes.size() > 0) begin
            check("read data", rdata & notes[0].m, notes[0].e);
            void'(notes.pop_front());
        end
        rd_d <= req.rd;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end
    // --------------------------------------------
    // Main sequence
    // --------------------------------------------
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        sample = '0;
        lfsr = 32'h1BB0;
        rd_d = 1'b0;
        n_fail = 0;
        n_compared = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            rd(ra[k], 24'hFFFFFF, rv[k]);
        end
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            wr(ADDR_CONFIG_A, lfsr[23:0]);
            rd(ADDR_CONFIG_A, 24'hFFFFFF, lfsr[23:0] & 24'hFFBF00);
            wr(ADDR_CONFIG_B, lfsr[31:8]);
            rd(ADDR_CONFIG_B, 24'hFFFFFF, lfsr[31:8] & 24'h3F3700);
        end
        wr(8'h7F, 24'hFFFFFF);
        rd(8'h7F, 24'hFFFFFF, 24'h0);
        $display("test registers done");
        wr(ADDR_CONFIG_B, 24'h0);
        wr(ADDR_IRQ_MASK, 24'h1);
        wr(ADDR_CONFIG_A, 24'h000300);
        wr(ADDR_MANAGE, 24'h000001);
        feed(8, 1'b1);
        see_pin(1'b0, 1'b0);
        wr(ADDR_CONFIG_A, 24'h008300);
        wr(ADDR_MANAGE, 24'h000000);
        feed(8, 1'b1);
        see_pin(1'b0, 1'b0);
        $display("test enable gate done");
        wr(ADDR_MANAGE, 24'h000001);
        feed(8, 1'b1);
        feed(24, 1'b0);
        see_pin(1'b1, 1'b1);
        wr(ADDR_IRQ_MASK, 24'h0);
        see_pin(1'b1, 1'b0);
        wr(ADDR_IRQ_MASK, 24'h1);
        rd(ADDR_STATUS, 24'h000003, 24'h000001);
        see_pin(1'b0, 1'b0);
        $display("test status policy done");
        wr(ADDR_MANAGE, 24'h000011);
        feed(8, 1'b1);
        feed(24, 1'b0);
        rd(ADDR_STATUS, 24'h000003, 24'h000001);
        see_pin(1'b1, 1'b1);
        rd(ADDR_INTERVAL, 24'hFFFFFF, 24'h0);
        see_pin(1'b0, 1'b0);
        $display("test interval policy done");
        wr(ADDR_MANAGE, 24'h000021);
        feed(8, 1'b1);
        feed(24, 1'b0);
        see_pin(1'b0, 1'b0);
        wr(ADDR_MANAGE, 24'h000031);
        feed(8, 1'b1);
        feed(24, 1'b0);
        see_pin(1'b1, 1'b1);
        wr(ADDR_MANAGE, 24'h000001);
        rd(ADDR_STATUS, 24'h000003, 24'h000001);
        see_pin(1'b0, 1'b0);
        $display("test self clear done");
        // Flag left set under the no-clear policy, then a mid-run reset must wipe it and every register
        wr(ADDR_MANAGE, 24'h000031);
        feed(8, 1'b1);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        see_pin(1'b0, 1'b0);
        for (int k = 0; k < 8; k++) begin
            rd(ra[k], 24'hFFFFFF, rv[k]);
        end
        $display("test mid-run reset done");
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule : testbench
`default_nettype wire
